// [hdl/link_node_params.svh]
// Named constants for the link node register group; its PHY-side partner uses none of them.
// Assumes inclusion by bare name from the link register group module only.
`ifndef LINK_NODE_PARAMS_SVH
`define LINK_NODE_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the software port)
// ----------------------------------------------------------------------------
`define ADDR_LINK_CTRL   8'he0
`define ADDR_NODE        8'he8
`define ADDR_PHY_ACCESS  8'hec
`define ADDR_TIMER       8'hf0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define NA_VALID   31
`define NA_ROOT    30
`define NA_CABLE   27
`define NA_BUS     15:6
`define NA_NODE    5:0
`define PA_DONE    31
`define PA_RET_IDX 27:24
`define PA_RET_VAL 23:16
`define PA_RD      15
`define PA_WR      14
`define PA_TGT     11:8
`define PA_WVAL    7:0
`define TM_SEC     31:25
`define TM_CNT     24:12
`define TM_OFF     11:0
`define LC_EXT     22
`define LC_MASTER  21
`define LC_RUN     20

// ----------------------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------------------
`define BUS_INDEX_RST  10'h3ff
`define NODE_INDEX_RST 6'h3f
`define OFFSET_LAST    12'hbff
`define COUNT_LAST     13'h1f3f
`define SECONDS_LAST   7'h7f

// ----------------------------------------------------------------------------
// Timebase: 24.576 MHz made from the 125 MHz clock by a phase accumulator
// ----------------------------------------------------------------------------
`define TB_FREQ_KHZ   18'h06000
`define CLK_FREQ_KHZ  18'h1e848

`endif

// [hdl/link_node_pkg.sv]
// Types shared by the link node register group and the PHY-side end.
// Assumes the constants header is on the include path.
package link_node_pkg;

    // ------------------------------------------------------------------------
    // Link-side state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [9:0]  bus_index;
        logic [5:0]  physical_node_index;
        logic        node_address_valid;
        logic        root;
        logic        cable_power_ok;
        logic        phy_read_complete;
        logic [3:0]  phy_returned_reg_index;
        logic [7:0]  phy_returned_value;
        logic        phy_read_request;
        logic        phy_write_request;
        logic [3:0]  phy_target_reg_index;
        logic [7:0]  phy_write_value;
        logic        req_valid;
        logic        req_write;
        logic [3:0]  req_index;
        logic [7:0]  req_value;
        logic [6:0]  isoch_seconds_tally;
        logic [12:0] isoch_period_tally;
        logic [11:0] subperiod_tick_tally;
        logic        timing_master_select;
        logic        timebase_run;
        logic        ext_tick_select;
        logic [17:0] tb_acc;
        logic        ext_s1;
        logic        ext_s2;
        logic        ext_s3;
        logic        cs_tx_valid;
        logic [31:0] cs_tx_data;
        logic [31:0] rdata;
    } link_state_s;

    // ------------------------------------------------------------------------
    // PHY-side state
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        PHY_IDLE  = 2'b01,
        PHY_REPLY = 2'b10
    } phy_fsm_e;

    typedef struct packed {
        phy_fsm_e         fsm;
        logic [15:0][7:0] regs;
        logic [3:0]       reply_index;
        logic             xfer_valid;
        logic [3:0]       xfer_index;
        logic [7:0]       xfer_value;
        logic             bus_reset;
        logic             selfid_done;
        logic [5:0]       node_number;
        logic             is_root;
        logic             cable_power;
        logic             cs_rx_valid;
        logic [31:0]      cs_rx_data;
        logic             cs_out_valid;
        logic [31:0]      cs_out_data;
    } phy_state_s;

endpackage : link_node_pkg

// [hdl/link_phy_if.sv]
// Signals between the link register group and the PHY-side end.
// Assumes both ends run on the same clock; every signal is a plain level.
`timescale 1ns/1ps

interface link_phy_if;
    // Register mailbox: link to PHY
    logic        req_valid;
    logic        req_write;
    logic [3:0]  req_index;
    logic [7:0]  req_value;
    // Register transfer: PHY to link
    logic        xfer_valid;
    logic [3:0]  xfer_index;
    logic [7:0]  xfer_value;
    // Bus status: PHY to link
    logic        bus_reset;
    logic        selfid_done;
    logic [5:0]  node_number;
    logic        is_root;
    logic        cable_power;
    // Cycle start packets
    logic        cs_rx_valid;
    logic [31:0] cs_rx_data;
    logic        cs_tx_valid;
    logic [31:0] cs_tx_data;

    modport link (
        output req_valid, req_write, req_index, req_value, cs_tx_valid, cs_tx_data,
        input  xfer_valid, xfer_index, xfer_value, bus_reset, selfid_done,
        input  node_number, is_root, cable_power, cs_rx_valid, cs_rx_data
    );

    modport phy (
        input  req_valid, req_write, req_index, req_value, cs_tx_valid, cs_tx_data,
        output xfer_valid, xfer_index, xfer_value, bus_reset, selfid_done,
        output node_number, is_root, cable_power, cs_rx_valid, cs_rx_data
    );
endinterface : link_phy_if

// [hdl/phy_core_end.sv]
// PHY-side end: holds sixteen 8-bit PHY registers, answers mailbox requests
// and forwards bus status and cycle start packets to the link.
// Assumes its user-side inputs come from logic on the same clock.
`timescale 1ns/1ps

module phy_core_end
    import link_node_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Link side
    link_phy_if.phy          link,
    // Bus status from the PHY core proper
    input  wire logic        bus_reset_in,
    input  wire logic        selfid_done_in,
    input  wire logic [5:0]  node_number_in,
    input  wire logic        is_root_in,
    input  wire logic        cable_power_in,
    // Cycle start packets from and to the wire
    input  wire logic        cs_in_valid,
    input  wire logic [31:0] cs_in_data,
    output logic             cs_out_valid,
    output logic [31:0]      cs_out_data
);

    phy_state_s q;
    phy_state_s d;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        d              = q;
        d.xfer_valid   = 1'b0;
        d.bus_reset    = bus_reset_in;
        d.selfid_done  = selfid_done_in;
        d.node_number  = node_number_in;
        d.is_root      = is_root_in;
        d.cable_power  = cable_power_in;
        d.cs_rx_valid  = cs_in_valid;
        d.cs_rx_data   = cs_in_data;
        d.cs_out_valid = link.cs_tx_valid;
        d.cs_out_data  = link.cs_tx_data;
        case (q.fsm)
            PHY_IDLE: begin
                if (link.req_valid) begin
                    if (link.req_write) begin
                        d.regs[link.req_index] = link.req_value;
                    end else begin
                        d.reply_index = link.req_index;
                        d.fsm         = PHY_REPLY;
                    end
                end
            end
            PHY_REPLY: begin
                // One request at a time; the link never overlaps them
                d.xfer_valid = 1'b1;
                d.xfer_index = q.reply_index;
                d.xfer_value = q.regs[q.reply_index];
                d.fsm        = PHY_IDLE;
            end
            default: begin
                d.fsm = PHY_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q     <= '0;
            q.fsm <= PHY_IDLE;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state flops
    assign link.xfer_valid  = q.xfer_valid;
    assign link.xfer_index  = q.xfer_index;
    assign link.xfer_value  = q.xfer_value;
    assign link.bus_reset   = q.bus_reset;
    assign link.selfid_done = q.selfid_done;
    assign link.node_number = q.node_number;
    assign link.is_root     = q.is_root;
    assign link.cable_power = q.cable_power;
    assign link.cs_rx_valid = q.cs_rx_valid;
    assign link.cs_rx_data  = q.cs_rx_data;
    assign cs_out_valid     = q.cs_out_valid;
    assign cs_out_data      = q.cs_out_data;

endmodule : phy_core_end

// [hdl/link_node_regs.sv]
// Link register group: node address, PHY register mailbox and the
// isochronous cycle timer, reached over a plain software register port.
// Assumes the PHY-side end shares clk; the 8 kHz tick is an async pin.
//
// Functional notes
// - Valid flag clears on bus reset, sets on node
// - Root flag set when PHY reports root
// - Cable-power flag follows PHY cable status
// - Node register reserved bits read zero
// - Node id is bus index plus node index
// - Node index loaded from PHY after self-id
// - Software avoids transmit run when node is 63
// - Read-complete clears when request bit written
// - PHY transfer stores index, value, sets complete
// - Read request sent, then its bit clears
// - Write request sent, then its bit clears
// - Software never sets both request bits
// - Target index and write value from fields
// - Access register reserved bits read zero
// - Offset counts timebase clocks modulo 3072
// - Period tally counts offset rollovers modulo 8000
// - Seconds tally counts period rollovers modulo 128
// - Timing master sends timer in cycle start
// - Non-master loads timer from received start
// - Timer keeps counting without received starts
// - External 8 kHz tick zeroes offset
// - Offset counts only while run bit set
// - Master and root send start each rollover
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "link_node_params.svh"

module link_node_regs
    import link_node_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Software register port
    input  wire logic [7:0]  sw_addr,
    input  wire logic [31:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic [31:0]      sw_rdata,
    // External 8 kHz cycle tick, asynchronous
    input  wire logic        ext_tick_8k,
    // PHY side
    link_phy_if.link         link
);

    link_state_s q;
    link_state_s d;

    // ------------------------------------------------------------------------
    // Timebase and tick detection
    // ------------------------------------------------------------------------
    logic [17:0] acc_sum;
    logic        tb_tick;
    logic        ext_edge;

    // Accumulator adds 24576 per 8 ns clock against 125000; jitter is one clock at most
    assign acc_sum  = q.tb_acc + `TB_FREQ_KHZ;
    assign tb_tick  = (acc_sum >= `CLK_FREQ_KHZ);
    // Edge taken from the second and third stages, never from the first
    assign ext_edge = q.ext_s2 & ~q.ext_s3;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        logic        roll;
        logic [31:0] word;
        roll        = 1'b0;
        word        = '0;
        d           = q;
        d.req_valid = 1'b0;
        d.cs_tx_valid = 1'b0;
        d.rdata     = '0;

        // Synchroniser and timebase accumulator
        d.ext_s1 = ext_tick_8k;
        d.ext_s2 = q.ext_s1;
        d.ext_s3 = q.ext_s2;
        d.tb_acc = tb_tick ? (acc_sum - `CLK_FREQ_KHZ) : acc_sum;

        // Node status from the PHY
        d.cable_power_ok = link.cable_power;
        if (link.bus_reset) begin
            d.node_address_valid = 1'b0;
            d.root               = 1'b0;
        end
        if (link.selfid_done) begin
            d.physical_node_index = link.node_number;
            d.node_address_valid  = 1'b1;
            d.root                = link.is_root;
        end

        // Mailbox: issue a pending request, clearing its bit as it goes out
        if ((q.phy_read_request | q.phy_write_request) && !q.req_valid) begin
            d.req_valid         = 1'b1;
            d.req_write         = !q.phy_read_request;
            d.req_index         = q.phy_target_reg_index;
            d.req_value         = q.phy_write_value;
            d.phy_read_request  = 1'b0;
            d.phy_write_request = 1'b0;
        end

        // Timer counting on the timebase, only while running
        if (q.timebase_run && tb_tick) begin
            if (q.subperiod_tick_tally == `OFFSET_LAST) begin
                // In external mode the tick, not the count, ends the cycle
                roll = !q.ext_tick_select;
            end else begin
                d.subperiod_tick_tally = q.subperiod_tick_tally + 12'h001;
            end
        end
        if (q.ext_tick_select && ext_edge) begin
            d.subperiod_tick_tally = '0;
            roll = q.timebase_run;
        end
        if (roll) begin
            d.subperiod_tick_tally = '0;
            if (q.isoch_period_tally == `COUNT_LAST) begin
                d.isoch_period_tally = '0;
                if (q.isoch_seconds_tally == `SECONDS_LAST) begin
                    d.isoch_seconds_tally = '0;
                end else begin
                    d.isoch_seconds_tally = q.isoch_seconds_tally + 7'h01;
                end
            end else begin
                d.isoch_period_tally = q.isoch_period_tally + 13'h0001;
            end
            if (q.timing_master_select && q.root) begin
                d.cs_tx_valid = 1'b1;
                d.cs_tx_data  = {d.isoch_seconds_tally, d.isoch_period_tally,
                                 d.subperiod_tick_tally};
            end
        end
        // A received start overrides local counting; without one it free-runs
        if (!q.timing_master_select && link.cs_rx_valid) begin
            d.isoch_seconds_tally  = link.cs_rx_data[`TM_SEC];
            d.isoch_period_tally   = link.cs_rx_data[`TM_CNT];
            d.subperiod_tick_tally = link.cs_rx_data[`TM_OFF];
        end

        // Software writes
        if (sw_wr) begin
            case (sw_addr)
                `ADDR_LINK_CTRL: begin
                    d.ext_tick_select      = sw_wdata[`LC_EXT];
                    d.timing_master_select = sw_wdata[`LC_MASTER];
                    d.timebase_run         = sw_wdata[`LC_RUN];
                end
                `ADDR_NODE: begin
                    d.bus_index = sw_wdata[`NA_BUS];
                end
                `ADDR_PHY_ACCESS: begin
                    d.phy_target_reg_index = sw_wdata[`PA_TGT];
                    d.phy_write_value      = sw_wdata[`PA_WVAL];
                    // Read wins if software breaks the one-at-a-time rule
                    d.phy_read_request  = sw_wdata[`PA_RD];
                    d.phy_write_request = sw_wdata[`PA_WR] & ~sw_wdata[`PA_RD];
                    if (sw_wdata[`PA_RD] | sw_wdata[`PA_WR]) begin
                        d.phy_read_complete = 1'b0;
                    end
                end
                `ADDR_TIMER: begin
                    d.isoch_seconds_tally  = sw_wdata[`TM_SEC];
                    d.isoch_period_tally   = sw_wdata[`TM_CNT];
                    d.subperiod_tick_tally = sw_wdata[`TM_OFF];
                end
                default: begin
                end
            endcase
        end

        // Transfer from the PHY; placed last so the set beats a clear
        if (link.xfer_valid) begin
            d.phy_returned_reg_index = link.xfer_index;
            d.phy_returned_value     = link.xfer_value;
            d.phy_read_complete      = 1'b1;
        end

        // Read data, standing only in the cycle after the strobe
        if (sw_rd) begin
            case (sw_addr)
                `ADDR_LINK_CTRL: begin
                    word[`LC_EXT]    = q.ext_tick_select;
                    word[`LC_MASTER] = q.timing_master_select;
                    word[`LC_RUN]    = q.timebase_run;
                end
                `ADDR_NODE: begin
                    word[`NA_VALID] = q.node_address_valid;
                    word[`NA_ROOT]  = q.root;
                    word[`NA_CABLE] = q.cable_power_ok;
                    word[`NA_BUS]   = q.bus_index;
                    word[`NA_NODE]  = q.physical_node_index;
                end
                `ADDR_PHY_ACCESS: begin
                    word[`PA_DONE]    = q.phy_read_complete;
                    word[`PA_RET_IDX] = q.phy_returned_reg_index;
                    word[`PA_RET_VAL] = q.phy_returned_value;
                    word[`PA_RD]      = q.phy_read_request;
                    word[`PA_WR]      = q.phy_write_request;
                    word[`PA_TGT]     = q.phy_target_reg_index;
                    word[`PA_WVAL]    = q.phy_write_value;
                end
                `ADDR_TIMER: begin
                    word[`TM_SEC] = q.isoch_seconds_tally;
                    word[`TM_CNT] = q.isoch_period_tally;
                    word[`TM_OFF] = q.subperiod_tick_tally;
                end
                default: begin
                    word = '0;
                end
            endcase
            d.rdata = word;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q                     <= '0;
            q.bus_index           <= `BUS_INDEX_RST;
            q.physical_node_index <= `NODE_INDEX_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state flops
    assign sw_rdata         = q.rdata;
    assign link.req_valid   = q.req_valid;
    assign link.req_write   = q.req_write;
    assign link.req_index   = q.req_index;
    assign link.req_value   = q.req_value;
    assign link.cs_tx_valid = q.cs_tx_valid;
    assign link.cs_tx_data  = q.cs_tx_data;

endmodule : link_node_regs

// [verif/link_node_checker.sv]
// Checker for the signals between the link end and the PHY end.
// Assumes one clock and the active-low asynchronous reset of both ends.
`timescale 1ns/1ps

module link_node_checker (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // Mailbox
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic [3:0]  req_index,
    input wire logic        xfer_valid,
    input wire logic [3:0]  xfer_index,
    // Status and cycle start
    input wire logic        bus_reset,
    input wire logic        cs_tx_valid,
    input wire logic [31:0] cs_tx_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------------------
    // Mailbox: a read gets exactly one reply, a write gets none
    // ------------------------------------------------------------------------
    a_req_one_cycle: assert property (req_valid |=> !req_valid)
        else $error("mailbox request longer than one cycle");
    a_read_reply: assert property ((req_valid && !req_write) |->
        ##2 (xfer_valid && xfer_index == $past(req_index, 2)))
        else $error("read request without matching reply");
    a_xfer_cause: assert property (xfer_valid |->
        ($past(req_valid, 2) && !$past(req_write, 2)))
        else $error("transfer without a read request");
    a_write_silent: assert property ((req_valid && req_write) |-> ##2 !xfer_valid)
        else $error("write request answered by a transfer");

    // ------------------------------------------------------------------------
    // Cycle start sent at rollover, so the offset is zero and starts are rare
    // ------------------------------------------------------------------------
    a_tx_offset_zero: assert property (cs_tx_valid |-> cs_tx_data[11:0] == 12'h000)
        else $error("cycle start offset not zero");
    a_tx_count_range: assert property (cs_tx_valid |-> cs_tx_data[24:12] < 13'h1f40)
        else $error("cycle start count out of range");
    a_tx_gap: assert property (cs_tx_valid |=> !cs_tx_valid [*8])
        else $error("cycle starts too close");
    a_reset_pulse: assert property ($rose(bus_reset) |=> $fell(bus_reset))
        else $error("bus reset not a single pulse");
endmodule : link_node_checker

// [verif/tb_link_node_phy_access_cycle_timer.sv]
// Self-checking bench: link register end and PHY end joined by the interface.
// Assumes a 125 MHz clock and software access over the plain strobe port.
`timescale 1ns/1ps

module tb_link_node_phy_access_cycle_timer;
    import link_node_pkg::*;

`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin miscompares++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end

    logic        clk = 0, rst_b = 0, sw_wr = 0, sw_rd = 0, ext_tick_8k = 0;
    logic [7:0]  sw_addr = 8'h00;
    logic [31:0] sw_wdata = 32'h0, sw_rdata, cs_in_data = 32'h0, cs_out_data, d;
    logic        bus_reset_in = 0, selfid_done_in = 0, is_root_in = 0;
    logic        cable_power_in = 1, cs_in_valid = 0, cs_out_valid;
    logic [5:0]  node_number_in = 6'h00;
    int          miscompares = 0, n_checks = 0;

    // ------------------------------------------------------------------------
    // Both ends and the checker
    // ------------------------------------------------------------------------
    link_phy_if lp ();
    link_node_regs u_link_node_regs (.clk, .rst_b, .sw_addr, .sw_wdata, .sw_wr, .sw_rd,
        .sw_rdata, .ext_tick_8k, .link(lp.link));
    phy_core_end u_phy_core_end (.clk, .rst_b, .link(lp.phy), .bus_reset_in,
        .selfid_done_in, .node_number_in, .is_root_in, .cable_power_in, .cs_in_valid,
        .cs_in_data, .cs_out_valid, .cs_out_data);
    link_node_checker u_link_node_checker (.clk, .rst_b, .req_valid(lp.req_valid),
        .req_write(lp.req_write), .req_index(lp.req_index), .xfer_valid(lp.xfer_valid),
        .xfer_index(lp.xfer_index), .bus_reset(lp.bus_reset),
        .cs_tx_valid(lp.cs_tx_valid), .cs_tx_data(lp.cs_tx_data));

    // Clock
    always #4 clk = ~clk;

    // ------------------------------------------------------------------------
    // Bus and status helpers
    // ------------------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        sw_addr <= a; sw_wdata <= v; sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe, so sample just after that edge
    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        sw_addr <= a; sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1 v = sw_rdata;
    endtask : rd

    task bus_evt(input logic brst, input logic [5:0] n, input logic r);
        @(posedge clk);
        if (brst) bus_reset_in <= 1'b1;
        else begin
            selfid_done_in <= 1'b1; node_number_in <= n; is_root_in <= r;
        end
        @(posedge clk);
        bus_reset_in <= 1'b0; selfid_done_in <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : bus_evt

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task t_node;
        // Cable status takes two cycles to pass both ends, so it still reads 0 here
        rd(8'he8, d); `CHK("node_rst", 32'h0000_ffff, d)
        rd(8'hec, d); `CHK("phy_rst", 32'h0, d)
        rd(8'h04, d); `CHK("unmapped", 32'h0, d)
        wr(8'he8, 32'hffff_a5c0);
        rd(8'he8, d); `CHK("bus_idx", 32'h0800_a5ff, d)
        bus_evt(0, 6'h05, 1); // No transmit context is ever run here
        rd(8'he8, d); `CHK("selfid", 32'hc800_a5c5, d)
        @(posedge clk);
        cable_power_in <= 1'b0;
        repeat (4) @(posedge clk);
        rd(8'he8, d); `CHK("cable", 32'hc000_a5c5, d)
        bus_evt(1, 6'h00, 0);
        rd(8'he8, d); `CHK("bus_rst", 32'h0000_a5c5, d)
        @(posedge clk);
        cable_power_in <= 1'b1;
        bus_evt(0, 6'h02, 1);
        rd(8'he8, d); `CHK("root", 32'hc800_a5c2, d)
    endtask : t_node

    task t_mailbox;
        wr(8'hec, 32'h0000_4355); // Only one request bit per write
        repeat (3) @(posedge clk);
        rd(8'hec, d); `CHK("wr_sent", 32'h0000_0355, d)
        wr(8'hec, 32'h0000_8300);
        repeat (6) @(posedge clk);
        rd(8'hec, d); `CHK("rd_done", 32'h8355_0300, d)
        wr(8'hec, 32'h0000_4aff);
        repeat (3) @(posedge clk);
        rd(8'hec, d); `CHK("done_clr", 32'h0355_0aff, d)
        wr(8'hec, 32'h0000_8a00);
        repeat (6) @(posedge clk);
        rd(8'hec, d); `CHK("rd_idx_a", 32'h8aff_0a00, d)
    endtask : t_mailbox

    task t_timer;
        wr(8'he0, 32'h0);
        wr(8'hf0, 32'hfff3_fbfe);
        rd(8'hf0, d); `CHK("tm_load", 32'hfff3_fbfe, d)
        repeat (20) @(posedge clk);
        rd(8'hf0, d); `CHK("hold", 32'hfff3_fbfe, d)
        wr(8'he0, 32'h0010_0000);
        repeat (20) @(posedge clk);
        rd(8'hf0, d); `CHK("wrap_hi", 20'h0, d[31:12])
        `CHK("wrap_off", 1'b1, d[11:0] < 12'h008)
    endtask : t_timer

    task t_master;
        wr(8'he0, 32'h0030_0000);
        wr(8'hf0, 32'h0000_5bfe);
        for (int i = 0; i < 40 && cs_out_valid !== 1'b1; i++) @(posedge clk) #1;
        `CHK("cs_sent", 1'b1, cs_out_valid)
        `CHK("cs_data", 32'h0000_6000, cs_out_data)
    endtask : t_master

    task t_receive;
        wr(8'he0, 32'h0);
        @(posedge clk);
        cs_in_valid <= 1'b1; cs_in_data <= 32'h1234_5678;
        @(posedge clk);
        cs_in_valid <= 1'b0;
        repeat (3) @(posedge clk);
        rd(8'hf0, d); `CHK("rx_load", 32'h1234_5678, d)
        wr(8'he0, 32'h0010_0000);
        repeat (40) @(posedge clk);
        rd(8'hf0, d); `CHK("free_hi", 20'h12345, d[31:12])
        `CHK("free_off", 1'b1, d[11:0] > 12'h678)
    endtask : t_receive

    task t_ext;
        wr(8'he0, 32'h0050_0000);
        wr(8'hf0, 32'h0000_0123);
        ext_tick_8k <= 1'b1;
        repeat (8) @(posedge clk);
        ext_tick_8k <= 1'b0;
        rd(8'hf0, d); `CHK("ext_cnt", 20'h00001, d[31:12])
        `CHK("ext_off", 1'b1, d[11:0] < 12'h008)
    endtask : t_ext

    // ------------------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------------------
    task complete_run;
        if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // Whole run is a few hundred cycles; this leaves ample margin
    initial begin
        #100000;
        miscompares++;
        complete_run;
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_node;
        t_mailbox;
        t_timer;
        t_master;
        t_receive;
        t_ext;
        complete_run;
    end
endmodule : tb_link_node_phy_access_cycle_timer
